/* File: dac_ctrl_regs.vh */
`ifndef DAC_CTRL_REGS_VH
`define DAC_CTRL_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CMD        8'h00
`define OFS_DATA       8'h04
`define OFS_STATUS     8'h08
`define OFS_VOLATILE   8'h0c
`define OFS_NONVOL     8'h10
`define OFS_OUTPUT     8'h14

// ----------------------------------------
// memory word layout: code in low bits, configuration above
// ----------------------------------------
`define DAC_W          12
`define CFG_W          5
`define MEM_W          17
`define CFG_LSB        12
`define CFG_GAIN       12
`define CFG_PD_LSB     13
`define CFG_PD_MSB     14
`define CFG_VREF_LSB   15
`define CFG_VREF_MSB   16

// ----------------------------------------
// command codes written to the command register
// ----------------------------------------
`define CMD_W            3
`define CMD_WR_VOL_DAC   3'h0
`define CMD_WR_VOL_MEM   3'h1
`define CMD_WR_ALL_MEM   3'h2
`define CMD_WR_VOL_CFG   3'h3
`define CMD_GC_RESET     3'h4
`define CMD_GC_WAKEUP    3'h5
`define CMD_READ         3'h6

// ----------------------------------------
// power-down selection codes
// ----------------------------------------
`define PD_NORMAL      2'h0
`define PD_1K          2'h1
`define PD_125K        2'h2
`define PD_640K        2'h3

// ----------------------------------------
// reset values
// ----------------------------------------
`define NV_RESET       17'h00000
`define VOL_SUPPLY_OFF 17'h06000

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ        125
`define POR_DELAY_NS   50000
`define PDE_NS         10000
`define PDD_NS         10000
`define PROG_NS        4000000

`endif

/* File: dac_pd_ctrl.v */
// How it works
// - power-down select 00 normal, 01 1k, 10 125k, 11 640k pulldown.
// - any power-down turns off amplifier and ladder, output high impedance, ladder unhooked.
// - power-down entry leaves volatile and nonvolatile code and configuration untouched.
// - after leaving normal, entry delay passes before amplifier stops and pulldown sinks.
// - only volatile writes, all-memory write, general call reset/wake-up and supply rise/fall change power-down select.
// - command port keeps working in every power-down selection.
// - power-down exit restores amplifier, ladder, reference, releases pulldown, uses volatile memory.
// - after select returns to normal, exit delay passes before amplifier drives output.
// - exit by write with normal code, general call wake-up, or reset with normal nonvolatile.
// - supply rise copies nonvolatile code and configuration into volatile memory.
// - supply rise starts reset delay timer; commands refused while it runs.
// - supply fall forces select to 11, rest of volatile to 0, refuses commands.
// - general call reset reloads volatile from nonvolatile without reset delay.
// - five configuration bits and a DAC code, volatile and nonvolatile copies each.
// - volatile memory alone drives analog output; master may update it.
// - all-memory write stores the same values into volatile memory too.
// - EEPROM programming starts at the acknowledge clock of the nonvolatile write; code starts it at the first serial clock rise after the command.
// - EEPROM-ready flag is 1 when idle, 0 while programming.
// - while programming, every command except read is ignored.
// - supply-good flag reads 1 above trip point, 0 when powered off.
// - status flags are volatile only, never loaded from EEPROM.
// - with supply as ladder reference, gain is one regardless of gain bit.
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_regs.vh"

module dac_pd_ctrl #(
	parameter POR_DELAY_NS = `POR_DELAY_NS,
	parameter PDE_NS       = `PDE_NS,
	parameter PDD_NS       = `PDD_NS,
	parameter PROG_NS      = `PROG_NS
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire        supply_good_pin,
	input  wire        scl_pin,
	output reg         amp_enable,
	output reg         output_hiz,
	output reg         ladder_enable,
	output reg         ladder_connect,
	output reg  [1:0]  pulldown_select,
	output reg  [11:0] dac_code_out,
	output reg  [1:0]  ladder_reference,
	output reg         gain_double
);

	// ----------------------------------------
	// cycle counts, least times rounded up
	// ----------------------------------------
	localparam integer POR_CYC_I  = (POR_DELAY_NS * `CLK_MHZ + 999) / 1000;
	localparam integer PDE_CYC_I  = (PDE_NS * `CLK_MHZ + 999) / 1000;
	localparam integer PDD_CYC_I  = (PDD_NS * `CLK_MHZ + 999) / 1000;
	localparam integer PROG_CYC_I = (PROG_NS * `CLK_MHZ + 999) / 1000;
	localparam [19:0]  POR_CYC    = (POR_CYC_I < 1) ? 20'h00001 : POR_CYC_I[19:0];
	localparam [19:0]  PDE_CYC    = (PDE_CYC_I < 1) ? 20'h00001 : PDE_CYC_I[19:0];
	localparam [19:0]  PDD_CYC    = (PDD_CYC_I < 1) ? 20'h00001 : PDD_CYC_I[19:0];
	localparam [19:0]  PROG_CYC   = (PROG_CYC_I < 1) ? 20'h00001 : PROG_CYC_I[19:0];

	localparam [1:0] ST_ON    = 2'h0;
	localparam [1:0] ST_ENTER = 2'h1;
	localparam [1:0] ST_DOWN  = 2'h2;
	localparam [1:0] ST_EXIT  = 2'h3;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	reg supply_s1_reg;
	reg supply_s2_reg;
	reg supply_d_reg;
	reg scl_s1_reg;
	reg scl_s2_reg;
	reg scl_d_reg;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			supply_s1_reg <= 1'b0;
			supply_s2_reg <= 1'b0;
			supply_d_reg  <= 1'b0;
			// serial clock idles high: starting high avoids a false edge after reset
			scl_s1_reg    <= 1'b1;
			scl_s2_reg    <= 1'b1;
			scl_d_reg     <= 1'b1;
		end
		else
		begin
			supply_s1_reg <= supply_good_pin;
			supply_s2_reg <= supply_s1_reg;
			supply_d_reg  <= supply_s2_reg;
			scl_s1_reg    <= scl_pin;
			scl_s2_reg    <= scl_s1_reg;
			scl_d_reg     <= scl_s2_reg;
		end
	end

	wire supply_rise = supply_s2_reg & ~supply_d_reg;
	wire supply_fall = ~supply_s2_reg & supply_d_reg;
	wire scl_rise    = scl_s2_reg & ~scl_d_reg;

	// ----------------------------------------
	// bus slave: address phase captured, write applied in data phase
	// ----------------------------------------
	reg        wr_pend_reg;
	reg [7:0]  wr_addr_reg;
	reg [31:0] data_reg;
	reg [16:0] vol_reg;
	reg [16:0] nv_reg;
	reg [16:0] nv_pend_reg;
	reg        refused_reg;
	reg        prog_wait_reg;
	reg        prog_busy_reg;
	reg [19:0] prog_cnt_reg;
	reg        por_busy_reg;
	reg [19:0] por_cnt_reg;
	reg [1:0]  state_reg;
	reg [1:0]  state_next;
	reg [19:0] pd_cnt_reg;
	reg [19:0] pd_cnt_next;
	reg [31:0] rd_mux;

	wire addr_phase = hsel & htrans[1] & hready;
	wire cmd_strobe = wr_pend_reg & (wr_addr_reg == `OFS_CMD);
	wire [2:0] cmd_code = hwdata[2:0];
	wire eeprom_ready = ~(prog_wait_reg | prog_busy_reg);
	// reads pass while programming; nothing passes during reset delay or without supply
	wire link_open = supply_s2_reg & ~por_busy_reg;
	wire cmd_ok = cmd_strobe & link_open & (eeprom_ready | (cmd_code == `CMD_READ));
	wire cmd_refused = cmd_strobe & ~cmd_ok;

	always @*
	begin
		case (haddr)
			`OFS_CMD:      rd_mux = 32'h00000000;
			`OFS_DATA:     rd_mux = data_reg;
			`OFS_STATUS:   rd_mux = {26'h0000000, state_reg, por_busy_reg, refused_reg,
			                         supply_s2_reg, eeprom_ready};
			`OFS_VOLATILE: rd_mux = {15'h0000, vol_reg};
			`OFS_NONVOL:   rd_mux = {15'h0000, nv_reg};
			`OFS_OUTPUT:   rd_mux = {11'h000, gain_double, ladder_reference, pulldown_select,
			                         dac_code_out, ladder_connect, ladder_enable, output_hiz, amp_enable};
			default:       rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata      <= 32'h00000000;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			data_reg    <= 32'h00000000;
			refused_reg <= 1'b0;
		end
		else
		begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= addr_phase & hwrite;
			if (addr_phase)
				wr_addr_reg <= haddr;
			if (addr_phase & ~hwrite)
				hrdata <= rd_mux;
			if (wr_pend_reg & (wr_addr_reg == `OFS_DATA))
				data_reg <= hwdata;
			// a refusal in the clearing cycle still sticks
			if (cmd_refused)
				refused_reg <= 1'b1;
			else if (wr_pend_reg & (wr_addr_reg == `OFS_STATUS) & hwdata[2])
				refused_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// volatile and nonvolatile memory
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			vol_reg       <= `VOL_SUPPLY_OFF;
			nv_reg        <= `NV_RESET;
			nv_pend_reg   <= `NV_RESET;
			prog_wait_reg <= 1'b0;
			prog_busy_reg <= 1'b0;
			prog_cnt_reg  <= 20'h00000;
			por_busy_reg  <= 1'b0;
			por_cnt_reg   <= 20'h00000;
		end
		else if (supply_fall)
		begin
			vol_reg       <= `VOL_SUPPLY_OFF;
			prog_wait_reg <= 1'b0;
			prog_busy_reg <= 1'b0;
			por_busy_reg  <= 1'b0;
		end
		else if (supply_rise)
		begin
			vol_reg      <= nv_reg;
			por_busy_reg <= 1'b1;
			por_cnt_reg  <= POR_CYC;
		end
		else
		begin
			if (por_busy_reg)
			begin
				por_cnt_reg <= por_cnt_reg - 20'h00001;
				if (por_cnt_reg == 20'h00001)
					por_busy_reg <= 1'b0;
			end
			// cells are written from the first serial clock rise after the command onward
			if (prog_wait_reg & scl_rise)
			begin
				prog_wait_reg <= 1'b0;
				prog_busy_reg <= 1'b1;
				prog_cnt_reg  <= PROG_CYC;
			end
			if (prog_busy_reg)
			begin
				prog_cnt_reg <= prog_cnt_reg - 20'h00001;
				if (prog_cnt_reg == 20'h00001)
				begin
					prog_busy_reg <= 1'b0;
					nv_reg        <= nv_pend_reg;
				end
			end
			if (cmd_ok)
			begin
				case (cmd_code)
					`CMD_WR_VOL_DAC:
					begin
						vol_reg[`DAC_W-1:0]                  <= hwdata[`DAC_W-1:0];
						vol_reg[`CFG_PD_MSB:`CFG_PD_LSB]     <= hwdata[`CFG_PD_MSB:`CFG_PD_LSB];
					end
					`CMD_WR_VOL_MEM:
						vol_reg <= hwdata[`MEM_W-1:0];
					`CMD_WR_ALL_MEM:
					begin
						vol_reg       <= data_reg[`MEM_W-1:0];
						nv_pend_reg   <= data_reg[`MEM_W-1:0];
						prog_wait_reg <= 1'b1;
					end
					`CMD_WR_VOL_CFG:
						vol_reg[`CFG_VREF_MSB:`CFG_LSB] <= data_reg[`CFG_VREF_MSB:`CFG_LSB];
					`CMD_GC_RESET:
						vol_reg <= nv_reg;
					`CMD_GC_WAKEUP:
						vol_reg[`CFG_PD_MSB:`CFG_PD_LSB] <= `PD_NORMAL;
					default:
						vol_reg <= vol_reg;
				endcase
			end
		end
	end

	// ----------------------------------------
	// power-down sequencing
	// ----------------------------------------
	wire [1:0] pd_sel = vol_reg[`CFG_PD_MSB:`CFG_PD_LSB];

	always @*
	begin
		state_next  = state_reg;
		pd_cnt_next = (pd_cnt_reg == 20'h00000) ? 20'h00000 : pd_cnt_reg - 20'h00001;
		case (state_reg)
			ST_ON:
				if (pd_sel != `PD_NORMAL)
				begin
					state_next  = ST_ENTER;
					pd_cnt_next = PDE_CYC;
				end
			ST_ENTER:
				if (pd_sel == `PD_NORMAL)
					state_next = ST_ON;
				else if (pd_cnt_reg == 20'h00001)
					state_next = ST_DOWN;
			ST_DOWN:
				if (pd_sel == `PD_NORMAL)
				begin
					state_next  = ST_EXIT;
					pd_cnt_next = PDD_CYC;
				end
			ST_EXIT:
				if (pd_sel != `PD_NORMAL)
					state_next = ST_DOWN;
				else if (pd_cnt_reg == 20'h00001)
					state_next = ST_ON;
			default:
				state_next = ST_DOWN;
		endcase
	end

	// analog control outputs only change state; stored memory never touched here
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg        <= ST_DOWN;
			pd_cnt_reg       <= 20'h00000;
			amp_enable       <= 1'b0;
			output_hiz       <= 1'b1;
			ladder_enable    <= 1'b0;
			ladder_connect   <= 1'b0;
			pulldown_select  <= `PD_640K;
			dac_code_out     <= 12'h000;
			ladder_reference <= 2'h0;
			gain_double      <= 1'b0;
		end
		else
		begin
			state_reg      <= state_next;
			pd_cnt_reg     <= pd_cnt_next;
			amp_enable     <= (state_next == ST_ON) | (state_next == ST_ENTER);
			output_hiz     <= (state_next == ST_DOWN) | (state_next == ST_EXIT);
			ladder_enable  <= (state_next != ST_DOWN);
			ladder_connect <= (state_next != ST_DOWN);
			// pulldown only once the amplifier has let go
			pulldown_select  <= (state_next == ST_DOWN) ? pd_sel : `PD_NORMAL;
			dac_code_out     <= vol_reg[`DAC_W-1:0];
			ladder_reference <= vol_reg[`CFG_VREF_MSB:`CFG_VREF_LSB];
			// supply reference leaves the gain at one
			gain_double      <= vol_reg[`CFG_GAIN] & vol_reg[`CFG_VREF_MSB];
		end
	end

endmodule // dac_pd_ctrl
`default_nettype wire

/* File: dac_pd_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checks
// ----------------------------------------
module dac_pd_monitor (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        supply_good_pin,
	input wire logic        amp_enable,
	input wire logic        output_hiz,
	input wire logic        ladder_enable,
	input wire logic        ladder_connect,
	input wire logic [1:0]  pulldown_select,
	input wire logic [11:0] dac_code_out,
	input wire logic [1:0]  ladder_reference,
	input wire logic        gain_double
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	ready_hi_a: assert property (hreadyout && !hresp)
		else $error("bus stalled or error");
	hiz_amp_a: assert property (output_hiz == !amp_enable)
		else $error("hiz and amp disagree");
	pd_off_a: assert property (pulldown_select != 2'h0 |-> !ladder_enable && !ladder_connect)
		else $error("ladder live in power-down");
	pd_amp_a: assert property (amp_enable |-> pulldown_select == 2'h0)
		else $error("pulldown with amp on");
	gain_one_a: assert property (!ladder_reference[1] |-> !gain_double)
		else $error("gain two on supply ref");
	// supply loss clears the code on purpose, so it is excluded
	code_keep_a: assert property ($rose(pulldown_select != 2'h0) && supply_good_pin |-> $stable(dac_code_out))
		else $error("code moved at power-down");
	entry_hold_a: assert property ($fell(amp_enable) && supply_good_pin |-> $past(amp_enable, 8))
		else $error("amp stopped too soon");
	exit_delay_a: assert property ($rose(amp_enable) |-> $past(ladder_enable, 4))
		else $error("amp drove too soon");
endmodule // dac_pd_monitor

bind dac_pd_ctrl dac_pd_monitor i_mon (.hclk, .hresetn, .hreadyout, .hresp, .supply_good_pin, .amp_enable,
	.output_hiz, .ladder_enable, .ladder_connect, .pulldown_select, .dac_code_out, .ladder_reference, .gain_double);
`default_nettype wire

/* File: scl_master.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// serial master: nine clocks a frame
// ----------------------------------------
module scl_master (
	input wire logic go,
	output var logic scl_pin
);
	// line idles high through its pull-up between frames
	initial scl_pin = 1'b1;
	always @(posedge go)
	begin
		// keep clock edges off the sampling edge of hclk
		#3;
		repeat (9)
		begin
			#43 scl_pin = 1'b0;
			#37 scl_pin = 1'b1;
		end
	end
endmodule // scl_master
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_regs.vh"
module tb_top;
	typedef struct packed {logic [2:0] c; logic [31:0] d; logic [31:0] e;} row_t;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, supply_good_pin = 0, go = 0;
	logic [7:0]  haddr = 0;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 0, hrdata, rd;
	logic        hreadyout, hresp, scl_pin, amp_enable, output_hiz, ladder_enable, ladder_connect, gain_double;
	logic [1:0]  pulldown_select, ladder_reference;
	logic [11:0] dac_code_out;
	int          n_errors = 0, compares = 0, cyc = 0;
	// ----------------------------------------
	// rows: command, word, expected output register
	// ----------------------------------------
	// in command 0 and 1 rows the low code bits equal the command, so the word survives either reading of the cmd write
	row_t rows[9] = '{'{3'h0, 32'h2120, 32'h11202}, '{3'h5, 32'h0, 32'h0120d},
		'{3'h1, 32'h150f9, 32'h1a0f92}, '{3'h3, 32'h9000, 32'h40f9d}, '{3'h0, 32'h6ab8, 32'h7ab82},
		'{3'h4, 32'h0, 32'h0000d}, '{3'h2, 32'h2456, 32'h14562}, '{3'h4, 32'h0, 32'h14562},
		'{3'h5, 32'h0, 32'h0456d}};
	always #4 hclk = ~hclk;
	dac_pd_ctrl #(.POR_DELAY_NS(100), .PDE_NS(100), .PDD_NS(100), .PROG_NS(100)) i_dut (.hclk, .hresetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.supply_good_pin, .scl_pin, .amp_enable, .output_hiz, .ladder_enable, .ladder_connect,
		.pulldown_select, .dac_code_out, .ladder_reference, .gain_double);
	scl_master i_scl (.go, .scl_pin);
	task conclude;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task poll(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		for (int k = 0; k < 200; k++)
		begin
			xfer(a, 1'b0, 32'h0);
			if ((rd & m) === e)
				break;
		end
		chk(nm, e, rd & m);
	endtask
	task frame;
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		// let the whole frame pass so frames never overlap
		repeat (100) @(posedge hclk);
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc > 40000)
		begin
			n_errors++;
			conclude;
		end
	end
	initial
	begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		poll("unpowered out", `OFS_OUTPUT, 32'h3ffff, 32'h30002);
		xfer(`OFS_CMD, 1'b1, 32'h5);
		xfer(`OFS_STATUS, 1'b0, 32'h0);
		chk("refused unpowered", 32'h4, rd & 32'h6);
		supply_good_pin <= 1'b1;
		xfer(`OFS_STATUS, 1'b1, 32'h4);
		xfer(`OFS_CMD, 1'b1, 32'h5);
		xfer(`OFS_STATUS, 1'b0, 32'h0);
		chk("refused in delay", 32'hc, rd & 32'hc);
		poll("delay over", `OFS_STATUS, 32'hf, 32'h7);
		xfer(`OFS_STATUS, 1'b1, 32'h4);
		poll("rise load", `OFS_OUTPUT, 32'h1fffff, 32'h0000d);
		foreach (rows[i])
		begin
			xfer(`OFS_DATA, 1'b1, rows[i].d);
			xfer(`OFS_CMD, 1'b1, {rows[i].d[31:3], rows[i].c});
			frame;
			poll("row out", `OFS_OUTPUT, 32'h1fffff, rows[i].e);
			poll("row ready", `OFS_STATUS, 32'h5, 32'h1);
		end
		xfer(`OFS_CMD, 1'b1, 32'h2000);
		repeat (2) @(posedge hclk);
		#1;
		chk("entry amp", 32'h1, {31'h0, amp_enable});
		poll("entry out", `OFS_OUTPUT, 32'h3ffff, 32'h10002);
		xfer(`OFS_DATA, 1'b1, 32'h778);
		xfer(`OFS_CMD, 1'b1, 32'h2);
		xfer(`OFS_CMD, 1'b1, 32'h6);
		xfer(`OFS_STATUS, 1'b0, 32'h0);
		chk("busy read", 32'h0, rd & 32'h5);
		xfer(`OFS_NONVOL, 1'b0, 32'h0);
		chk("nonvol waits", 32'h2456, rd);
		xfer(`OFS_CMD, 1'b1, 32'h2000);
		xfer(`OFS_STATUS, 1'b0, 32'h0);
		chk("busy status", 32'h4, rd & 32'h5);
		xfer(`OFS_OUTPUT, 1'b0, 32'h0);
		chk("busy ignore", 32'h7780, rd & 32'h3fff0);
		frame;
		poll("prog done", `OFS_STATUS, 32'h1, 32'h1);
		xfer(`OFS_NONVOL, 1'b0, 32'h0);
		chk("nonvol", 32'h778, rd);
		supply_good_pin <= 1'b0;
		poll("fall vol", `OFS_VOLATILE, 32'h1ffff, 32'h6000);
		xfer(`OFS_STATUS, 1'b0, 32'h0);
		chk("fall status", 32'h1, rd & 32'h3);
		supply_good_pin <= 1'b1;
		poll("rise vol", `OFS_VOLATILE, 32'h1ffff, 32'h778);
		poll("rise status", `OFS_STATUS, 32'hb, 32'h3);
		conclude;
	end
endmodule // tb_top
`default_nettype wire
